// file: design/cnsg_map.svh
// Address windows, bit positions and reset values for the strobe glue
`ifndef CNSG_MAP_SVH
`define CNSG_MAP_SVH

// ----------------------------------------------------------------
// Chip-select windows, decoded from the top nibble of the address
// ----------------------------------------------------------------
`define CNSG_WIN_MSB 31
`define CNSG_WIN_LSB 28
`define CNSG_CS3_WIN 4'h4
`define CNSG_CS4_WIN 4'h5
`define CNSG_CS5_WIN 4'h6

// ----------------------------------------------------------------
// Address bit positions
// ----------------------------------------------------------------
`define CNSG_MODE_MSB 23
`define CNSG_MODE_LSB 21
`define CNSG_ALE_BIT 21
`define CNSG_CLE_BIT 22
`define CNSG_A25_BIT 25

// ----------------------------------------------------------------
// Card mode codes on address bits 23..21
// ----------------------------------------------------------------
`define CNSG_CODE_ATTR 3'h0
`define CNSG_CODE_COMMON 3'h2
`define CNSG_CODE_IO 3'h4
`define CNSG_CODE_IDE 3'h6
`define CNSG_CODE_ALT_IDE 3'h7

// ----------------------------------------------------------------
// Reset and idle levels
// ----------------------------------------------------------------
`define CNSG_STROBE_IDLE 1'h1
`define CNSG_ADDR_RST 1'h0
`define CNSG_FLAG_RST 1'h0

`endif

// file: design/cnsg_pkg.sv
// Types shared by the card and flash strobe glue
`default_nettype none
package cnsg_pkg;

  // ----------------------------------------------------------------
  // Signals from the static bus controller, all strobes active low
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic xfer_write;
    logic chip_select_three_n;
    logic chip_select_four_n;
    logic chip_select_five_n;
    logic read_strobe_n;
    logic write_strobe_low_n;
    logic write_or_byte1_strobe_n;
    logic write_or_byte3_strobe_n;
  } cnsg_smc_t;

  // ----------------------------------------------------------------
  // Shared and dedicated external pins
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs3_pin_n;
    logic cs4_pin_n;
    logic cs5_pin_n;
    logic rd_pin_n;
    logic wr0_pin_n;
    logic wr1_pin_n;
    logic wr3_pin_n;
    logic a25_pin;
    logic flash_output_enable_n;
    logic flash_write_enable_n;
    logic flash_addr_latch;
    logic flash_cmd_latch;
  } cnsg_pins_t;

  // ----------------------------------------------------------------
  // Card mode, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    CNSG_MODE_NONE = 6'h01,
    CNSG_MODE_ATTR = 6'h02,
    CNSG_MODE_COMMON = 6'h04,
    CNSG_MODE_IO = 6'h08,
    CNSG_MODE_IDE = 6'h10,
    CNSG_MODE_ALT_IDE = 6'h20
  } cnsg_mode_t;

endpackage : cnsg_pkg
`default_nettype wire

// file: design/cnsg_strobe_route.sv
// Gates one read/write strobe pair onto an enabled output pair
`timescale 1ns/1ps
`default_nettype none
`include "cnsg_map.svh"

module cnsg_strobe_route (
  input wire logic i_enable,   // Route strobes when high
  input wire logic i_rd_n,     // Controller read strobe
  input wire logic i_wr_n,     // Controller write strobe
  output logic o_rd_n,         // Routed read strobe
  output logic o_wr_n          // Routed write strobe
);

  // Disabled pair parks high so the device sees no access
  assign o_rd_n = i_enable ? i_rd_n : `CNSG_STROBE_IDLE;
  assign o_wr_n = i_enable ? i_wr_n : `CNSG_STROBE_IDLE;

endmodule : cnsg_strobe_route
`default_nettype wire

// file: design/cnsg_glue.sv
// Card slot and NAND flash strobe steering for the external bus pins
`timescale 1ns/1ps
`default_nettype none
`include "cnsg_map.svh"

module cnsg_glue (
  input wire logic i_clk,                       // System clock
  input wire logic i_sys_rst,                   // Async reset, high
  input wire logic i_ce,                        // Clock enable
  input wire cnsg_pkg::cnsg_smc_t i_smc,        // Controller signals
  input wire logic i_select3_flash_assign,      // Select 3 to flash
  input wire logic i_select4_card_assign,       // Select 4 to slot 0
  input wire logic i_select5_card_assign,       // Select 5 to slot 1
  input wire logic i_card_wait_n,               // Card wait, low
  output var cnsg_pkg::cnsg_pins_t o_pins,      // External pins
  output logic o_external_wait_in_n,            // To controller wait
  output var cnsg_pkg::cnsg_mode_t o_card_mode, // Decoded card mode
  output logic o_card_access,                   // Card access running
  output logic o_flash_access                   // Flash access running
);

  // ----------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------
  wire logic [3:0] win_nibble;
  wire logic in_cs3_win;
  wire logic in_cs4_win;
  wire logic in_cs5_win;

  assign win_nibble = i_smc.addr[`CNSG_WIN_MSB:`CNSG_WIN_LSB];
  assign in_cs3_win = (win_nibble == `CNSG_CS3_WIN);
  assign in_cs4_win = (win_nibble == `CNSG_CS4_WIN);
  assign in_cs5_win = (win_nibble == `CNSG_CS5_WIN);

  // ----------------------------------------------------------------
  // Access qualification
  // ----------------------------------------------------------------
  wire logic slot0_access;
  wire logic slot1_access;
  wire logic card_access;
  wire logic flash_access;

  // Select alone is not trusted; the window must agree as well
  assign slot0_access = i_select4_card_assign & ~i_smc.chip_select_four_n
                        & in_cs4_win;
  assign slot1_access = i_select5_card_assign & ~i_smc.chip_select_five_n
                        & in_cs5_win;
  assign card_access = slot0_access | slot1_access;

  // Drops the moment the address leaves the window
  assign flash_access = i_select3_flash_assign
                        & ~i_smc.chip_select_three_n
                        & in_cs3_win;

  // ----------------------------------------------------------------
  // Card mode decode
  // ----------------------------------------------------------------
  wire logic [2:0] mode_code;
  cnsg_pkg::cnsg_mode_t mode_dec;

  assign mode_code = i_smc.addr[`CNSG_MODE_MSB:`CNSG_MODE_LSB];

  // Codes outside the table select nothing: both pairs stay parked
  assign mode_dec =
    !card_access ? cnsg_pkg::CNSG_MODE_NONE :
    (mode_code == `CNSG_CODE_ATTR) ? cnsg_pkg::CNSG_MODE_ATTR :
    (mode_code == `CNSG_CODE_COMMON) ? cnsg_pkg::CNSG_MODE_COMMON :
    (mode_code == `CNSG_CODE_IO) ? cnsg_pkg::CNSG_MODE_IO :
    (mode_code == `CNSG_CODE_IDE) ? cnsg_pkg::CNSG_MODE_IDE :
    (mode_code == `CNSG_CODE_ALT_IDE) ? cnsg_pkg::CNSG_MODE_ALT_IDE :
    cnsg_pkg::CNSG_MODE_NONE;

  wire logic mem_route_en;
  wire logic io_route_en;

  assign mem_route_en = (mode_dec == cnsg_pkg::CNSG_MODE_ATTR)
                      | (mode_dec == cnsg_pkg::CNSG_MODE_COMMON);
  assign io_route_en = (mode_dec == cnsg_pkg::CNSG_MODE_IO)
                     | (mode_dec == cnsg_pkg::CNSG_MODE_IDE)
                     | (mode_dec == cnsg_pkg::CNSG_MODE_ALT_IDE);

  // ----------------------------------------------------------------
  // Strobe routing
  // ----------------------------------------------------------------
  wire logic card_oe_n;
  wire logic card_we_n;
  wire logic card_ior_n;
  wire logic card_iow_n;
  wire logic flash_oe_n;
  wire logic flash_we_n;

  cnsg_strobe_route u_card_mem (
    .i_enable(mem_route_en),
    .i_rd_n(i_smc.read_strobe_n),
    .i_wr_n(i_smc.write_strobe_low_n),
    .o_rd_n(card_oe_n),
    .o_wr_n(card_we_n)
  );

  cnsg_strobe_route u_card_io (
    .i_enable(io_route_en),
    .i_rd_n(i_smc.read_strobe_n),
    .i_wr_n(i_smc.write_strobe_low_n),
    .o_rd_n(card_ior_n),
    .o_wr_n(card_iow_n)
  );

  cnsg_strobe_route u_flash (
    .i_enable(flash_access),
    .i_rd_n(i_smc.read_strobe_n),
    .i_wr_n(i_smc.write_strobe_low_n),
    .o_rd_n(flash_oe_n),
    .o_wr_n(flash_we_n)
  );

  // ----------------------------------------------------------------
  // Pin selection
  // ----------------------------------------------------------------
  cnsg_pkg::cnsg_pins_t pins_next;
  wire logic card_read_not_write;

  // Direction level, not a strobe, so it spans the whole transfer
  assign card_read_not_write = ~i_smc.xfer_write;

  // Card selects follow their controller select, held high while assigned and the address is outside their window
  assign pins_next.cs4_pin_n = i_smc.chip_select_four_n
                               | (i_select4_card_assign & ~in_cs4_win);
  assign pins_next.cs5_pin_n = i_smc.chip_select_five_n
                               | (i_select5_card_assign & ~in_cs5_win);
  assign pins_next.cs3_pin_n = i_smc.chip_select_three_n;

  assign pins_next.rd_pin_n = card_access ? card_oe_n
                              : i_smc.read_strobe_n;
  assign pins_next.wr0_pin_n = card_access ? card_we_n
                               : i_smc.write_strobe_low_n;
  assign pins_next.wr1_pin_n = card_access ? card_ior_n
                               : i_smc.write_or_byte1_strobe_n;
  assign pins_next.wr3_pin_n = card_access ? card_iow_n
                               : i_smc.write_or_byte3_strobe_n;
  assign pins_next.a25_pin = card_access ? card_read_not_write
                             : i_smc.addr[`CNSG_A25_BIT];

  assign pins_next.flash_output_enable_n = flash_oe_n;
  assign pins_next.flash_write_enable_n = flash_we_n;
  assign pins_next.flash_addr_latch = i_smc.addr[`CNSG_ALE_BIT];
  assign pins_next.flash_cmd_latch = i_smc.addr[`CNSG_CLE_BIT];

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Every pin goes through one flop, so all keep their mutual timing
  cnsg_pkg::cnsg_pins_t pins_reg;
  cnsg_pkg::cnsg_mode_t mode_reg;
  logic card_access_reg;
  logic flash_access_reg;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pins_reg.cs3_pin_n <= `CNSG_STROBE_IDLE;
      pins_reg.cs4_pin_n <= `CNSG_STROBE_IDLE;
      pins_reg.cs5_pin_n <= `CNSG_STROBE_IDLE;
      pins_reg.rd_pin_n <= `CNSG_STROBE_IDLE;
      pins_reg.wr0_pin_n <= `CNSG_STROBE_IDLE;
      pins_reg.wr1_pin_n <= `CNSG_STROBE_IDLE;
      pins_reg.wr3_pin_n <= `CNSG_STROBE_IDLE;
      pins_reg.a25_pin <= `CNSG_ADDR_RST;
      pins_reg.flash_output_enable_n <= `CNSG_STROBE_IDLE;
      pins_reg.flash_write_enable_n <= `CNSG_STROBE_IDLE;
      pins_reg.flash_addr_latch <= `CNSG_ADDR_RST;
      pins_reg.flash_cmd_latch <= `CNSG_ADDR_RST;
    end
    else if (i_ce)
    begin
      pins_reg <= pins_next;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      mode_reg <= cnsg_pkg::CNSG_MODE_NONE;
      card_access_reg <= `CNSG_FLAG_RST;
      flash_access_reg <= `CNSG_FLAG_RST;
    end
    else if (i_ce)
    begin
      mode_reg <= mode_dec;
      card_access_reg <= card_access;
      flash_access_reg <= flash_access;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_pins = pins_reg;
  assign o_card_mode = mode_reg;
  assign o_card_access = card_access_reg;
  assign o_flash_access = flash_access_reg;

  // Plain wire so a card can stretch the access without added lag
  assign o_external_wait_in_n = i_card_wait_n;

endmodule : cnsg_glue
`default_nettype wire

// file: tb/cnsg_glue_monitor.sv
// Concurrent checks on the strobe glue ports
`timescale 1ns/1ps
`default_nettype none
module cnsg_glue_monitor (
  input wire logic i_clk, // Clock
  input wire logic i_sys_rst, // Reset
  input wire logic i_ce, // Enable
  input wire cnsg_pkg::cnsg_smc_t i_smc, // Controller
  input wire logic i_select3_flash_assign, // Assign 3
  input wire logic i_select4_card_assign, // Assign 4
  input wire logic i_select5_card_assign, // Assign 5
  input wire logic i_card_wait_n, // Card wait
  input wire cnsg_pkg::cnsg_pins_t o_pins, // Pins
  input wire logic o_external_wait_in_n, // Wait out
  input wire cnsg_pkg::cnsg_mode_t o_card_mode, // Mode
  input wire logic o_card_access, // Card flag
  input wire logic o_flash_access // Flash flag
);
  logic live_reg;
  wire [3:0] nib = i_smc.addr[31:28];
  wire [2:0] code = i_smc.addr[23:21];
  wire card = (i_select4_card_assign && !i_smc.chip_select_four_n &&
    nib == 4'h5) || (i_select5_card_assign &&
    !i_smc.chip_select_five_n && nib == 4'h6);
  wire io = code == 3'h4 || code[2:1] == 2'h3;
  wire mem = code == 3'h0 || code == 3'h2;
  wire flash = i_select3_flash_assign && !i_smc.chip_select_three_n &&
    nib == 4'h4;
  wire plain = !i_select3_flash_assign && !i_select4_card_assign &&
    !i_select5_card_assign;
  // Masks the first edge after reset, where outputs still hold reset values
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      live_reg <= 1'h0;
    else
      live_reg <= 1'h1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_io_strobes: assert property (
    live_reg && $past(i_ce && card && io) |-> o_pins.rd_pin_n &&
    o_pins.wr0_pin_n && o_pins.wr1_pin_n == $past(i_smc.read_strobe_n) &&
    o_pins.wr3_pin_n == $past(i_smc.write_strobe_low_n))
    else $error("io mode strobes misrouted");
  a_mem_strobes: assert property (
    live_reg && $past(i_ce && card && mem) |-> o_pins.wr1_pin_n &&
    o_pins.wr3_pin_n && o_pins.rd_pin_n == $past(i_smc.read_strobe_n) &&
    o_pins.wr0_pin_n == $past(i_smc.write_strobe_low_n))
    else $error("memory mode strobes misrouted");
  a_slot0_select: assert property (
    live_reg && $past(i_ce && i_select4_card_assign && nib == 4'h5) |->
    o_pins.cs4_pin_n == $past(i_smc.chip_select_four_n))
    else $error("slot 0 select lost select four timing");
  a_card_dir: assert property (
    live_reg && $past(i_ce && card) |-> o_card_access &&
    o_pins.a25_pin != $past(i_smc.xfer_write))
    else $error("card direction wrong");
  a_plain_pass: assert property (
    live_reg && $past(i_ce && plain) |-> o_pins.a25_pin ==
    $past(i_smc.addr[25]) && o_pins.rd_pin_n == $past(i_smc.read_strobe_n)
    && o_pins.wr1_pin_n == $past(i_smc.write_or_byte1_strobe_n) &&
    o_pins.cs4_pin_n == $past(i_smc.chip_select_four_n))
    else $error("unassigned pins not passed through");
  a_flash_strobes: assert property (
    live_reg && $past(i_ce && flash) |-> o_flash_access &&
    o_pins.flash_write_enable_n == $past(i_smc.write_strobe_low_n) &&
    o_pins.flash_output_enable_n == $past(i_smc.read_strobe_n))
    else $error("flash strobes misrouted");
  a_flash_off: assert property (
    live_reg && $past(i_ce && nib != 4'h4) |-> !o_flash_access &&
    o_pins.flash_write_enable_n && o_pins.flash_output_enable_n)
    else $error("flash strobes active outside window");
  a_latch_bits: assert property (
    live_reg && $past(i_ce) |-> {o_pins.flash_cmd_latch,
    o_pins.flash_addr_latch} == $past(i_smc.addr[22:21]))
    else $error("latch lines differ from address");
  c_card_io: cover property (card && io);
  c_flash: cover property (flash);
  c_frozen: cover property (!i_ce);
endmodule : cnsg_glue_monitor
bind cnsg_glue cnsg_glue_monitor u_mon (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_smc(i_smc),
  .i_select3_flash_assign(i_select3_flash_assign),
  .i_select4_card_assign(i_select4_card_assign),
  .i_select5_card_assign(i_select5_card_assign),
  .i_card_wait_n(i_card_wait_n), .o_pins(o_pins),
  .o_external_wait_in_n(o_external_wait_in_n), .o_card_mode(o_card_mode),
  .o_card_access(o_card_access), .o_flash_access(o_flash_access));
`default_nettype wire

// file: tb/cnsg_card_slot.sv
// Card slot model that stretches accesses through its wait line
`timescale 1ns/1ps
`default_nettype none
module cnsg_card_slot (
  input wire logic i_clk, // Clock
  input wire cnsg_pkg::cnsg_pins_t i_pins, // Pins
  input wire logic i_slow, // Stretch accesses
  output logic o_wait_n // Wait, low
);
  int cnt = 0;
  // Reset, interrupt and detect ride on general pins, not here
  // Slow card pulls wait for two cycles once selected; pull-up otherwise
  always @(negedge i_clk)
  begin
    cnt = (i_slow && !i_pins.cs4_pin_n) ? cnt + 1 : 0;
    o_wait_n <= !(cnt inside {[1:2]});
  end
endmodule : cnsg_card_slot
`default_nettype wire

// file: tb/cnsg_glue_tb.sv
// Self-checking bench for the card and flash strobe glue
`timescale 1ns/1ps
`default_nettype none
module cnsg_glue_tb;
  logic clk = 1'h0, rst = 1'h1, ce = 1'h1, slow = 1'h0, wait_n;
  logic [2:0] asg = 3'h0;
  cnsg_pkg::cnsg_smc_t static_bus_controller = cnsg_pkg::cnsg_smc_t'({32'h0, 8'h7f});
  cnsg_pkg::cnsg_pins_t pins, prev;
  cnsg_pkg::cnsg_mode_t mode;
  logic wait_o, cacc, facc;
  int err_count = 0, cmp_count = 0;
  initial forever #5 clk = ~clk;
  cnsg_glue DUT (.i_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_smc(static_bus_controller),
    .i_select3_flash_assign(asg[2]), .i_select4_card_assign(asg[1]),
    .i_select5_card_assign(asg[0]), .i_card_wait_n(wait_n), .o_pins(pins),
    .o_external_wait_in_n(wait_o), .o_card_mode(mode),
    .o_card_access(cacc), .o_flash_access(facc));
  cnsg_card_slot u_slot (.i_clk(clk), .i_pins(pins), .i_slow(slow),
    .o_wait_n(wait_n));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic cnsg_pkg::cnsg_pins_t exp_pins(
      cnsg_pkg::cnsg_smc_t s, logic [2:0] a);
    cnsg_pkg::cnsg_pins_t p;
    logic [3:0] n;
    logic c, io, mem, f;
    n = s.addr[31:28];
    c = (a[1] && !s.chip_select_four_n && n == 4'h5) ||
      (a[0] && !s.chip_select_five_n && n == 4'h6);
    io = s.addr[23:21] inside {3'h4, 3'h6, 3'h7};
    mem = s.addr[23:21] inside {3'h0, 3'h2};
    f = a[2] && !s.chip_select_three_n && n == 4'h4;
    p.cs3_pin_n = s.chip_select_three_n;
    p.cs4_pin_n = s.chip_select_four_n || (a[1] && n != 4'h5);
    p.cs5_pin_n = s.chip_select_five_n || (a[0] && n != 4'h6);
    p.rd_pin_n = c ? (s.read_strobe_n || !mem) : s.read_strobe_n;
    p.wr0_pin_n = c ? (s.write_strobe_low_n || !mem) : s.write_strobe_low_n;
    p.wr1_pin_n = c ? (s.read_strobe_n || !io) : s.write_or_byte1_strobe_n;
    p.wr3_pin_n = c ? (s.write_strobe_low_n || !io)
      : s.write_or_byte3_strobe_n;
    p.a25_pin = c ? !s.xfer_write : s.addr[25];
    p.flash_output_enable_n = s.read_strobe_n || !f;
    p.flash_write_enable_n = s.write_strobe_low_n || !f;
    p.flash_addr_latch = s.addr[21];
    p.flash_cmd_latch = s.addr[22];
    return p;
  endfunction : exp_pins
  // Strobes st are {read, write low, byte1, byte3}; cs is {three, four, five}
  task automatic step(input logic [31:0] ad, input logic w,
      input logic [2:0] cs, input logic [3:0] st, input logic [2:0] a);
    cnsg_pkg::cnsg_smc_t s;
    s = cnsg_pkg::cnsg_smc_t'({ad, w, cs, st});
    @(negedge clk);
    static_bus_controller = s;
    asg = a;
    @(negedge clk);
    chk(pins, exp_pins(s, a));
  endtask : step
  task automatic t_card_modes();
    logic [2:0] codes [5] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h7};
    logic [5:0] modes [5] = '{6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
    for (int i = 0; i < 5; i++)
    begin
      step({8'h50, codes[i], 21'h0}, 1'h0, 3'h5, 4'h7, 3'h2);
      chk({6'h0, mode}, {6'h0, modes[i]});
      chk({10'h0, cacc, pins.a25_pin}, 12'h3);
      step({8'h50, codes[i], 21'h0}, 1'h1, 3'h5, 4'hb, 3'h2);
    end
    $display("t_card_modes done");
  endtask : t_card_modes
  task automatic t_slots_and_pass();
    step(32'h6080_0000, 1'h1, 3'h6, 4'hb, 3'h1);
    step(32'h6080_0000, 1'h0, 3'h5, 4'h7, 3'h3);
    step(32'h5020_0000, 1'h0, 3'h5, 4'h7, 3'h2);
    step(32'h5280_0000, 1'h0, 3'h5, 4'h5, 3'h0);
    step(32'h5280_0000, 1'h1, 3'h5, 4'ha, 3'h0);
    chk({11'h0, cacc}, 12'h0);
    $display("t_slots_and_pass done");
  endtask : t_slots_and_pass
  task automatic t_flash();
    // Chip enable and busy sit on general pins, outside
    step(32'h4040_0000, 1'h1, 3'h3, 4'hb, 3'h4);
    chk({11'h0, facc}, 12'h1);
    step(32'h4020_0000, 1'h0, 3'h3, 4'h7, 3'h4);
    step(32'h5020_0000, 1'h0, 3'h3, 4'h7, 3'h4);
    chk({11'h0, facc}, 12'h0);
    $display("t_flash done");
  endtask : t_flash
  task automatic t_wait_freeze();
    logic saw_low;
    saw_low = 1'h0;
    slow = 1'h1;
    for (int i = 0; i < 5; i++)
    begin
      step(32'h5080_0000, 1'h0, 3'h5, 4'h7, 3'h2);
      chk({11'h0, wait_o}, {11'h0, wait_n});
      saw_low = saw_low | !wait_n;
    end
    chk({11'h0, saw_low}, 12'h1);
    slow = 1'h0;
    prev = pins;
    ce = 1'h0;
    static_bus_controller = cnsg_pkg::cnsg_smc_t'({32'h4060_0000, 8'h00});
    @(negedge clk);
    chk(pins, prev);
    chk({6'h0, mode}, 12'h008);
    chk({11'h0, cacc}, 12'h1);
    ce = 1'h1;
    $display("t_wait_freeze done");
  endtask : t_wait_freeze
  // Reset in mid-run during a card access, then a flash access after it
  task automatic t_mid_reset();
    step(32'h5080_0000, 1'h0, 3'h5, 4'h7, 3'h2);
    rst = 1'h1;
    @(negedge clk);
    chk(pins, 12'hfec);
    chk({6'h0, mode}, 12'h001);
    chk({10'h0, cacc, facc}, 12'h0);
    rst = 1'h0;
    step(32'h4040_0000, 1'h1, 3'h3, 4'hb, 3'h4);
    chk({10'h0, cacc, facc}, 12'h1);
    $display("t_mid_reset done");
  endtask : t_mid_reset
  task automatic tally_and_finish();
    $display("Counts: %0d mismatches, %0d comparisons", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #50us;
    err_count++;
    tally_and_finish();
  end
  initial
  begin
    repeat (16) @(negedge clk);
    chk(pins, 12'hfec);
    chk({6'h0, mode}, 12'h001);
    rst = 1'h0;
    t_card_modes();
    t_slots_and_pass();
    t_flash();
    t_wait_freeze();
    t_mid_reset();
    tally_and_finish();
  end
endmodule : cnsg_glue_tb
`default_nettype wire
